// ==== hw/ftbs_sram.sv ====
// flow-through burst sram port with storage
`timescale 1ns/1ps
`default_nettype none
`include "ftbs_defs.svh"
module ftbs_sram (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // static configuration
   input wire logic wide_mode,
   input wire logic burst_order,
   // address and control, active low except depth_select_a
   input wire logic [`FTBS_ADDR_W-1:0] addr,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic pipelined_chip_select_n,
   input wire logic depth_select_a,
   input wire logic depth_select_b_n,
   input wire logic [`FTBS_LANES-1:0] byte_lane_write_n,
   input wire logic byte_write_gate_n,
   input wire logic all_bytes_write_n,
   // asynchronous controls
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // shared data bus
   input wire logic [`FTBS_DATA_W-1:0] data_in,
   output logic [`FTBS_DATA_W-1:0] data_out,
   output logic data_oe_n
);
   localparam int DEPTH = `FTBS_WIDE_DEPTH;
   logic [`FTBS_DATA_W-1:0] mem [0:DEPTH-1];
   logic [`FTBS_ADDR_W-1:0] base_addr;
   logic [1:0] start_bits;
   logic [1:0] step;
   logic selected;
   ftbs_pkg::ftbs_state_t state;
   logic [`FTBS_DATA_W-1:0] read_reg;
   logic drive_reg;
   logic strobe;
   logic load;
   logic advance;
   logic chip_on;
   logic acc_sel;
   logic [1:0] cur_low;
   logic [1:0] next_step;
   logic [1:0] acc_low;
   logic [`FTBS_ADDR_W-1:0] cur_addr;
   logic [`FTBS_ADDR_W-1:0] acc_addr;
   logic [`FTBS_LANES-1:0] lane_we;
   logic [17:0] word_index;
   logic narrow_hi;
   logic write_go;
   logic read_go;
   logic [`FTBS_DATA_W-1:0] mem_word;
   logic [`FTBS_DATA_W-1:0] next_read;

   // ------------------------------------------------------------
   // burst address step
   // ------------------------------------------------------------
   function automatic logic [1:0] burst_low(input logic [1:0] s,
         input logic [1:0] n, input logic il);
      if (il)
         burst_low = s ^ n;
      else
         burst_low = 2'(s + n);
   endfunction : burst_low

   // ------------------------------------------------------------
   // narrow half select
   // ------------------------------------------------------------
   function automatic logic [`FTBS_DATA_W-1:0] half_pick(
         input logic [`FTBS_DATA_W-1:0] w,
         input logic hi,
         input logic wide);
      if (wide)
         half_pick = w;
      else if (hi)
         half_pick = {18'h00000, w[35:18]};
      else
         half_pick = {18'h00000, w[17:0]};
   endfunction : half_pick

   // ------------------------------------------------------------
   // strobes, selects and access address
   // ------------------------------------------------------------
   assign strobe = !processor_addr_strobe_n || !controller_addr_strobe_n;
   assign chip_on = !pipelined_chip_select_n && depth_select_a
      && !depth_select_b_n;
   // processor strobe only counts while the pipelined select is low
   assign load = !sleep_request && (!controller_addr_strobe_n
      || (!processor_addr_strobe_n && !pipelined_chip_select_n));
   assign advance = !load && !burst_advance_n && selected
      && !sleep_request;
   assign next_step = 2'(step + 2'h1);
   assign cur_low = burst_low(start_bits, step, burst_order);
   assign acc_low = burst_low(start_bits, advance ? next_step : step,
      burst_order);
   assign cur_addr = {base_addr[`FTBS_ADDR_W-1:2], cur_low};
   assign acc_addr = load ? addr : {base_addr[`FTBS_ADDR_W-1:2], acc_low};
   assign acc_sel = load ? chip_on : selected;

   // narrow mode maps two half words onto one wide word
   assign word_index = wide_mode ? acc_addr[17:0] : acc_addr[18:1];
   assign narrow_hi = !wide_mode && acc_addr[0];
   assign write_go = acc_sel && !sleep_request && processor_addr_strobe_n
      && (|lane_we);
   assign read_go = acc_sel && !sleep_request && !(|lane_we);

   // ------------------------------------------------------------
   // address capture and burst counter
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         base_addr <= '0;
         start_bits <= 2'h0;
         step <= 2'h0;
         selected <= 1'b0;
      end else if (sleep_request) begin
         selected <= 1'b0;
      end else if (load) begin
         base_addr <= addr;
         start_bits <= addr[1:0];
         step <= 2'h0;
         selected <= chip_on;
      end else if (advance) begin
         step <= next_step;
      end
   end

   // ------------------------------------------------------------
   // byte lane write decode
   // ------------------------------------------------------------
   always_comb begin
      lane_we = '0;
      if (!all_bytes_write_n)
         lane_we = '1;
      else if (!byte_write_gate_n)
         lane_we = ~byte_lane_write_n;
      if (!wide_mode)
         lane_we = narrow_hi ? {lane_we[1:0], 2'h0} : {2'h0, lane_we[1:0]};
   end

   // ------------------------------------------------------------
   // access state
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ftbs_pkg::FTBS_IDLE;
      end else if (!acc_sel || sleep_request) begin
         state <= ftbs_pkg::FTBS_IDLE;
      end else begin
         case (write_go)
            1'b1: state <= ftbs_pkg::FTBS_WRITE;
            default: state <= ftbs_pkg::FTBS_READ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // storage, written at the edge that carries the address unless the processor strobe is low
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (write_go) begin
         for (int i = 0; i < `FTBS_LANES; i++) begin
            if (lane_we[i])
               mem[word_index][i*`FTBS_LANE_W +: `FTBS_LANE_W] <=
                  (wide_mode ? data_in[i*`FTBS_LANE_W +: `FTBS_LANE_W]
                             : data_in[(i%2)*`FTBS_LANE_W +: `FTBS_LANE_W]);
         end
      end
   end

   // ------------------------------------------------------------
   // flow-through read of the addressed word
   // ------------------------------------------------------------
   assign mem_word = mem[word_index];
   assign next_read = half_pick(mem_word, narrow_hi, wide_mode);

   always_ff @(posedge clk) begin
      if (reset) begin
         read_reg <= '0;
         drive_reg <= 1'b0;
      end else begin
         read_reg <= next_read;
         drive_reg <= read_go;
      end
   end

   // ------------------------------------------------------------
   // outputs; enable and sleep act without a clock
   // ------------------------------------------------------------
   assign data_out = read_reg;
   assign data_oe_n = !(drive_reg && !output_enable_n
      && !sleep_request);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_burst_start;
      load && chip_on;
   endsequence

   sequence s_burst_step;
      advance;
   endsequence

   sequence s_write_cycle;
      write_go;
   endsequence

   property p_oe_async;
      @(posedge clk) disable iff (reset)
      output_enable_n |-> data_oe_n;
   endproperty
   a_oe_async: assert property (p_oe_async)
      else $error("bus driven while disabled");

   property p_sleep_idle;
      @(posedge clk) disable iff (reset)
      sleep_request |=> !selected;
   endproperty
   a_sleep_idle: assert property (p_sleep_idle)
      else $error("still selected in sleep");

   property p_sleep_quiet;
      @(posedge clk) disable iff (reset)
      sleep_request |-> data_oe_n;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("bus driven in sleep");

   property p_load_strobe;
      @(posedge clk) disable iff (reset)
      !load |=> $stable(base_addr);
   endproperty
   a_load_strobe: assert property (p_load_strobe)
      else $error("load without strobe");

   property p_step_hold;
      @(posedge clk) disable iff (reset)
      !load && !advance |=> $stable(step);
   endproperty
   a_step_hold: assert property (p_step_hold)
      else $error("step moved idle");

   property p_step_clear;
      @(posedge clk) disable iff (reset)
      strobe && !processor_addr_strobe_n && !pipelined_chip_select_n
      && !sleep_request |=> step == 2'h0;
   endproperty
   a_step_clear: assert property (p_step_clear)
      else $error("step not cleared");

   property p_inter_order;
      @(posedge clk) disable iff (reset)
      burst_order |-> cur_low == (start_bits ^ step);
   endproperty
   a_inter_order: assert property (p_inter_order)
      else $error("bad interleave");

   property p_linear_order;
      @(posedge clk) disable iff (reset)
      !burst_order |-> cur_low == 2'(start_bits + step);
   endproperty
   a_linear_order: assert property (p_linear_order)
      else $error("bad linear");

   property p_global_write;
      @(posedge clk) disable iff (reset)
      !all_bytes_write_n && wide_mode |-> lane_we == 4'hf;
   endproperty
   a_global_write: assert property (p_global_write)
      else $error("global write");

   property p_ctrl_load;
      @(posedge clk) disable iff (reset)
      !controller_addr_strobe_n && !sleep_request |=> base_addr == $past(addr);
   endproperty
   a_ctrl_load: assert property (p_ctrl_load)
      else $error("controller strobe did not load");

   property p_proc_load;
      @(posedge clk) disable iff (reset)
      !processor_addr_strobe_n && !pipelined_chip_select_n && !sleep_request
      |=> base_addr == $past(addr);
   endproperty
   a_proc_load: assert property (p_proc_load)
      else $error("processor strobe did not load");

   property p_proc_ignored;
      @(posedge clk) disable iff (reset)
      !processor_addr_strobe_n && pipelined_chip_select_n
      && controller_addr_strobe_n |=> $stable(base_addr);
   endproperty
   a_proc_ignored: assert property (p_proc_ignored)
      else $error("processor strobe loaded while unselected");

   property p_deselect;
      @(posedge clk) disable iff (reset)
      !controller_addr_strobe_n && pipelined_chip_select_n
      && !sleep_request |=> !selected;
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("select kept after deselect");

   property p_burst_cadence;
      @(posedge clk) disable iff (reset)
      s_burst_start ##1 s_burst_step |=> step == 2'h1;
   endproperty
   a_burst_cadence: assert property (p_burst_cadence)
      else $error("burst step missed");

   property p_adv_step;
      @(posedge clk) disable iff (reset)
      s_burst_step |=> step == $past(next_step);
   endproperty
   a_adv_step: assert property (p_adv_step)
      else $error("advance did not step");

   property p_lane_gate;
      @(posedge clk) disable iff (reset)
      all_bytes_write_n && byte_write_gate_n |-> lane_we == 4'h0;
   endproperty
   a_lane_gate: assert property (p_lane_gate)
      else $error("lane write without gate");

   property p_write_state;
      @(posedge clk) disable iff (reset)
      s_write_cycle |=> state == ftbs_pkg::FTBS_WRITE && data_oe_n;
   endproperty
   a_write_state: assert property (p_write_state)
      else $error("write cycle drove the bus");

   property p_drive_state;
      @(posedge clk) disable iff (reset)
      drive_reg |-> state == ftbs_pkg::FTBS_READ;
   endproperty
   a_drive_state: assert property (p_drive_state)
      else $error("drive outside a read");

   property p_narrow_upper;
      @(posedge clk) disable iff (reset)
      !wide_mode |=> read_reg[35:18] == 18'h00000;
   endproperty
   a_narrow_upper: assert property (p_narrow_upper)
      else $error("narrow read upper half set");

   property p_hold_addr;
      @(posedge clk) disable iff (reset)
      acc_sel && !load && !advance |-> acc_addr == cur_addr;
   endproperty
   a_hold_addr: assert property (p_hold_addr)
      else $error("burst address moved");
endmodule : ftbs_sram
`default_nettype wire

// ==== hw/ftbs_defs.svh ====
// constants for the flow-through burst sram port
// Contract
// - offers 256K x 36 or 512K x 18 words over one shared data bus.
// - every synchronous input is sampled on the rising clock edge.
// - output enable and sleep act on the outputs without a clock.
// - burst start address held in a 2-bit counter, then incremented.
// - burst order pin high steps interleaved, low steps linear.
// - either address strobe starts a burst; the processor strobe only while the pipelined select is low.
// - address and chip enables load only on an edge with a strobe.
// - burst counter moves only with advance, driven by the master.
// - burst cadence of two cycles first, then one cycle each.
// - byte lane, byte gate and global write sampled to pick bytes.
`ifndef FTBS_DEFS_SVH
`define FTBS_DEFS_SVH
`define FTBS_ADDR_W 19
`define FTBS_DATA_W 36
`define FTBS_LANES 4
`define FTBS_LANE_W 9
`define FTBS_WIDE_DEPTH 262144
`define FTBS_NARROW_DEPTH 524288
`define FTBS_BURST_LEN 4
`endif

// ==== hw/ftbs_pkg.sv ====
// types for the flow-through burst sram port
package ftbs_pkg;
   typedef enum logic [1:0] {
      FTBS_IDLE = 2'b00,
      FTBS_READ = 2'b01,
      FTBS_WRITE = 2'b10
   } ftbs_state_t;
endpackage : ftbs_pkg

// ==== sim/ftbs_master.sv ====
// bus master model driving the sram port
`timescale 1ns/1ps
`default_nettype none
`include "ftbs_defs.svh"
module ftbs_master (
   // clock
   input wire logic clk,
   // address and control
   output logic [`FTBS_ADDR_W-1:0] addr,
   output logic [3:0] ctl_n,
   output logic [5:0] wen_n,
   // write data
   output logic [`FTBS_DATA_W-1:0] data_in
);
   initial begin
      addr = '0;
      ctl_n = 4'hf;
      wen_n = 6'h3f;
      data_in = '0;
   end
   // one bus cycle: strobes, advance, select, write enables
   task automatic drive(input logic [18:0] a, input logic [3:0] c,
         input logic [5:0] w, input logic [35:0] d);
      @(posedge clk);
      addr <= a;
      ctl_n <= c;
      wen_n <= w;
      data_in <= (w[5:4] != 2'h3) ? d : ~data_in;
   endtask : drive
endmodule : ftbs_master
`default_nettype wire

// ==== sim/ftbs_sram_tb_top.sv ====
// self-checking bench for the sram port
`timescale 1ns/1ps
`default_nettype none
module ftbs_sram_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic burst_order = 1'b0;
   logic wide_mode = 1'b1;
   logic oe_n = 1'b0;
   logic sleep = 1'b0;
   logic [18:0] addr;
   logic [3:0] ctl_n;
   logic [5:0] wen_n;
   logic [35:0] data_in, data_out, e, d1, d2;
   logic [35:0] mem [4];
   logic [35:0] exp_q [$];
   logic [18:0] base;
   logic data_oe_n;
   int seed = 32'hf36c;
   int mismatches = 0;
   int checks = 0;
   initial forever #12.5 clk = ~clk;
   ftbs_master u_master (.clk(clk), .addr(addr), .ctl_n(ctl_n),
      .wen_n(wen_n), .data_in(data_in));
   ftbs_sram u_dut (.clk(clk), .reset(reset), .wide_mode(wide_mode),
      .burst_order(burst_order), .addr(addr),
      .processor_addr_strobe_n(ctl_n[3]),
      .controller_addr_strobe_n(ctl_n[2]), .burst_advance_n(ctl_n[1]),
      .pipelined_chip_select_n(ctl_n[0]), .depth_select_a(1'b1),
      .depth_select_b_n(1'b0), .byte_lane_write_n(wen_n[3:0]),
      .byte_write_gate_n(wen_n[4]), .all_bytes_write_n(wen_n[5]),
      .output_enable_n(oe_n), .sleep_request(sleep), .data_in(data_in),
      .data_out(data_out), .data_oe_n(data_oe_n));
   task automatic stop_test;
      if (mismatches == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   // watchdog
   initial begin
      #20000;
      mismatches++;
      stop_test();
   end
   // output monitor
   always @(negedge clk) begin
      if (data_oe_n === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         checks++;
         if (data_out !== e) begin
            mismatches++;
            $display("Error data_out expected %h seen %h", e, data_out);
         end
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      for (int o = 0; o < 2; o++) begin
         for (int s = 0; s < 4; s++) begin
            burst_order <= o[0];
            base = 19'($random(seed)) & 19'h3fffc;
            for (int k = 0; k < 4; k++) begin
               mem[k] = {$random(seed), $random(seed)};
               u_master.drive(base | 19'(k), 4'ha, 6'h1f, mem[k]);
            end
            for (int k = 0; k < 4; k++)
               exp_q.push_back(mem[o ? (s ^ k) : ((s + k) % 4)]);
            u_master.drive(base | 19'(s), s[0] ? 4'h6 : 4'ha, 6'h3f, '0);
            repeat (3) u_master.drive(19'h7ffff, 4'hc, 6'h3f, '0);
            u_master.drive('0, 4'hb, 6'h3f, '0);
            u_master.drive('0, 4'hf, 6'h3f, '0);
         end
      end
      d1 = {$random(seed), $random(seed)};
      d2 = ~d1;
      u_master.drive(19'h100, 4'ha, 6'h1f, d1);
      u_master.drive(19'h100, 4'ha, 6'h2e, d2);
      exp_q.push_back({d1[35:9], d2[8:0]});
      u_master.drive(19'h100, 4'h6, 6'h3f, '0);
      u_master.drive('0, 4'hb, 6'h3f, '0);
      wide_mode <= 1'b0;
      d1 = {$random(seed), $random(seed)};
      d2 = {$random(seed), $random(seed)};
      u_master.drive(19'h201, 4'ha, 6'h1f, d1);
      u_master.drive(19'h200, 4'ha, 6'h1f, d2);
      exp_q.push_back({18'h00000, d1[17:0]});
      exp_q.push_back({18'h00000, d2[17:0]});
      u_master.drive(19'h201, 4'ha, 6'h3f, '0);
      u_master.drive(19'h200, 4'ha, 6'h3f, '0);
      u_master.drive('0, 4'hb, 6'h3f, '0);
      wide_mode <= 1'b1;
      for (int t = 0; t < 2; t++) begin
         @(posedge clk);
         oe_n <= !t[0];
         sleep <= t[0];
         u_master.drive(19'h100, 4'ha, 6'h3f, '0);
         u_master.drive('0, 4'hb, 6'h3f, '0);
         @(negedge clk);
         checks++;
         if (data_oe_n !== 1'b1) begin
            mismatches++;
            $display("Error data_oe_n expected 1 seen %b", data_oe_n);
         end
      end
      @(posedge clk);
      oe_n <= 1'b0;
      sleep <= 1'b0;
      repeat (4) u_master.drive('0, 4'hf, 6'h3f, '0);
      if (exp_q.size() != 0)
         mismatches++;
      stop_test();
   end
endmodule : ftbs_sram_tb_top
`default_nettype wire
